// *** verilog/wdgsr_top.sv ***
/*
  Watchdog downcounter with software reset and plain timer use.
  Assumes one 20 MHz clock, async active-low reset, and a Wishbone
  classic master that holds each request until ack.
*/
// The Wishbone register port and the register offsets were chosen for this implementation.
module wdgsr_top
  import wdgsr_pkg::*;
#(
  parameter int TICK_LEN = wdgsr_pkg::TICK_CYCLES
) (
  input  wire logic       SYS_CLK,
  input  wire logic       RESET_N,
  input  wire logic       HW_ACTIVATION,   // guard_activation_option
  input  wire logic       STOP_GATING,     // external_stop_gating_option
  input  wire logic       NMI_LEVEL,
  input  wire logic       STOP_REQ,
  input  wire logic       WAKEUP,
  input  wire logic       CYC_I,
  input  wire logic       STB_I,
  input  wire logic       WE_I,
  input  wire logic [3:0] ADR_I,
  input  wire logic [3:0] SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic      [31:0] DAT_O,
  output logic            ACK_O,
  output logic            RESET_PIN_N,
  output logic            STOPPED,
  output logic            WAIT_MODE,
  output logic            IRQ
);
  import wdgsr_pkg::*;

  typedef enum logic [2:0] {
    WDGSR_RUN   = 3'b001,
    WDGSR_PULSE = 3'b010,
    WDGSR_HALT  = 3'b100
  } wdgsr_state_t;

  wdgsr_state_t state;
  logic [6:0]   count;      // Physical count: restart flag is bit 6
  logic         arm;
  logic [11:0]  prescale;
  logic [4:0]   pulse_cnt;
  logic [EVT_W-1:0] status;
  logic [EVT_W-1:0] mask;
  logic [EVT_W-1:0] evt;
  logic         req;
  logic         wr_gcr;
  logic         tick;
  logic         active;
  logic         expire;

  // Convert physical count and flags to register byte
  function automatic logic [7:0] to_reg(input logic [6:0] c,
                                        input logic a);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 6; i++) r[TICK_LSB_POS - i] = c[i]; // [R15]
    r[RESTART_BIT] = c[6];
    r[ARM_BIT]     = a;
    return r;
  endfunction

  // Convert register byte to physical count
  function automatic logic [6:0] from_reg(input logic [7:0] r);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 0; i < 6; i++) c[i] = r[TICK_LSB_POS - i]; // [R15]
    c[6] = r[RESTART_BIT];
    return c;
  endfunction

  function automatic logic next_stop();
    // Stop is honoured only unarmed, or gated with line high  [R17]
    return STOP_REQ && (!active || (STOP_GATING && NMI_LEVEL));
  endfunction

  assign req    = CYC_I && STB_I && !ACK_O;
  assign wr_gcr = req && WE_I && SEL_I[0] && ADR_I == GCR_OFFSET;
  // Hardware option counts as armed from reset regardless of the flag
  assign active = arm || HW_ACTIVATION;                  // [R01]
  assign tick   = prescale == 12'(TICK_LEN - 1) && state == WDGSR_RUN;
  // Expiry when count's restart bit is zero while armed  [R05] [R16]
  assign expire = state == WDGSR_RUN && active && !count[6];
  assign evt    = {state == WDGSR_RUN && STOPPED == 1'b0 && next_stop(),
                   expire, tick};

  // Decrement divider; held at zero outside run state so counting resumes cleanly
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      prescale <= 12'h000;
    end else if (state != WDGSR_RUN || wr_gcr) begin
      prescale <= 12'h000;                               // [R18]
    end else if (tick) begin
      prescale <= 12'h000;                               // [R03]
    end else begin
      prescale <= prescale + 12'h001;
    end
  end

  // Counter keeps running unarmed so it doubles as a timer  [R09] [R11]
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      count <= from_reg(GCR_RESET);
    end else if (wr_gcr) begin
      count <= from_reg(DAT_I[7:0]);                     // [R18] [R04]
    end else if (state == WDGSR_PULSE && pulse_cnt == 5'h00) begin
      count <= from_reg(GCR_RESET);                      // [R05]
    end else if (tick) begin
      count <= count - 7'h01;                            // [R03]
    end
  end

  // Arm flag: set-only under software option, reset clears  [R02]
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      arm <= 1'b0;
    end else if (HW_ACTIVATION) begin
      arm <= 1'b1;                                       // [R01]
    end else if (wr_gcr && DAT_I[ARM_BIT]) begin
      arm <= 1'b1;                                       // [R02]
    end
  end

  // Run, reset pulse and stop states
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state     <= WDGSR_RUN;
      pulse_cnt <= 5'h00;
    end else begin
      case (state)
        WDGSR_RUN: begin
          // Immediate software reset also lands here: write leaves
          // the restart bit clear while armed  [R07]
          if (expire) begin
            state     <= WDGSR_PULSE;                    // [R05]
            pulse_cnt <= 5'(PULSE_CYCLES - 1);
          end else if (next_stop()) begin
            state <= WDGSR_HALT;                         // [R17]
          end
        end
        WDGSR_PULSE: begin
          // The count process reloads the reset image at the end;
          // otherwise the still-clear restart bit re-expires at once
          if (pulse_cnt == 5'h00) begin
            state <= WDGSR_RUN;
          end else begin
            pulse_cnt <= pulse_cnt - 5'h01;
          end
        end
        WDGSR_HALT: begin
          if (WAKEUP) begin
            state <= WDGSR_RUN;                          // [R17]
          end
        end
        default: state <= WDGSR_RUN;
      endcase
    end
  end

  // Pin and low-power outputs, all registered
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RESET_PIN_N <= 1'b1;
      STOPPED     <= 1'b0;
      WAIT_MODE   <= 1'b0;
    end else begin
      RESET_PIN_N <= !(expire || (state == WDGSR_PULSE &&
                                  pulse_cnt != 5'h00));  // [R05]
      STOPPED     <= (state == WDGSR_RUN && !expire && next_stop()) ||
                     (state == WDGSR_HALT && !WAKEUP);
      // Armed watchdog turns a stop into a wait  [R17]
      WAIT_MODE   <= STOP_REQ && active &&
                     !(STOP_GATING && NMI_LEVEL);
    end
  end

  // Sticky status: hardware set wins over write-one-to-clear
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      status <= '0;
      mask   <= '0;
    end else begin
      if (req && WE_I && SEL_I[0] && ADR_I == IRQ_MASK_OFFS) begin
        mask <= DAT_I[EVT_W-1:0];
      end
      if (req && WE_I && SEL_I[0] && ADR_I == IRQ_STAT_OFFS) begin
        status <= (status & ~DAT_I[EVT_W-1:0]) | evt;
      end else begin
        status <= status | evt;
      end
    end
  end

  // Single-wait-state slave; unmapped reads return zero
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h0000_0000;
      IRQ   <= 1'b0;
    end else begin
      ACK_O <= req;
      IRQ   <= |(status & mask);
      if (req && !WE_I) begin
        case (ADR_I)
          // Arm read shows flag; under hardware option it may read 0 [R08]
          GCR_OFFSET:    DAT_O <= {24'h000000, to_reg(count, arm)};
          IRQ_STAT_OFFS: DAT_O <= {29'h0, status};
          IRQ_MASK_OFFS: DAT_O <= {29'h0, mask};
          default:       DAT_O <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Rule checks, all on the system clock with reset as disable
  property p_tick_period;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    tick |=> !tick [*8];
  endproperty
  a_tick_period: assert property (p_tick_period) // [R03]
    else $error("decrement came too soon");

  property p_expire_pulse;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    expire |=> !RESET_PIN_N [*8];
  endproperty
  a_expire_pulse: assert property (p_expire_pulse) // [R05]
    else $error("reset pulse too short");

  property p_hw_arm;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    HW_ACTIVATION && RESET_N |=> arm;
  endproperty
  a_hw_arm: assert property (p_hw_arm) // [R01]
    else $error("arm not forced under hardware option");

  property p_arm_sticky;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    arm |=> arm;
  endproperty
  a_arm_sticky: assert property (p_arm_sticky) // [R02]
    else $error("arm flag dropped");

  property p_soft_reset;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    wr_gcr && active && !DAT_I[RESTART_BIT] && state == WDGSR_RUN
      |=> ##1 !RESET_PIN_N;
  endproperty
  a_soft_reset: assert property (p_soft_reset) // [R07]
    else $error("software reset not generated");

  property p_unarmed_no_reset;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    !active && state == WDGSR_RUN |=> RESET_PIN_N;
  endproperty
  a_unarmed_no_reset: assert property (p_unarmed_no_reset) // [R16]
    else $error("unarmed timer caused reset");

  property p_timer_runs;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    tick && !wr_gcr |=> count == $past(count) - 7'h01;
  endproperty
  a_timer_runs: assert property (p_timer_runs) // [R09]
    else $error("count did not decrement");

  property p_load;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    wr_gcr |=> count == from_reg($past(DAT_I[7:0])) && prescale == 0;
  endproperty
  a_load: assert property (p_load) // [R18]
    else $error("write not loaded");

  property p_stop_as_wait;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    STOP_REQ && active && !(STOP_GATING && NMI_LEVEL) |=> !STOPPED;
  endproperty
  a_stop_as_wait: assert property (p_stop_as_wait) // [R17]
    else $error("stop entered while watchdog active");

  property p_pulse_release;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    state == WDGSR_PULSE && pulse_cnt == 5'h00 |=> RESET_PIN_N;
  endproperty
  a_pulse_release: assert property (p_pulse_release) // [R05]
    else $error("reset pulse did not end");

  property p_pulse_reload;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    state == WDGSR_PULSE && pulse_cnt == 5'h00 && !wr_gcr
      |=> count == from_reg(GCR_RESET);
  endproperty
  a_pulse_reload: assert property (p_pulse_reload) // [R05]
    else $error("count not reloaded after reset pulse");

  property p_expire_status;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    expire |=> status[EVT_EXPIRE];
  endproperty
  a_expire_status: assert property (p_expire_status) // [R05]
    else $error("expiry not recorded in status");

  property p_arm_write;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    wr_gcr && DAT_I[ARM_BIT] |=> arm;
  endproperty
  a_arm_write: assert property (p_arm_write) // [R02]
    else $error("arm flag not set by write");

  property p_halt_freeze;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    state == WDGSR_HALT && !wr_gcr |=> count == $past(count);
  endproperty
  a_halt_freeze: assert property (p_halt_freeze) // [R17]
    else $error("count moved while stopped");

  property p_prescale_hold;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    state != WDGSR_RUN |=> prescale == 12'h000;
  endproperty
  a_prescale_hold: assert property (p_prescale_hold) // [R17]
    else $error("divider ran outside run state");

  property p_stop_entry;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    state == WDGSR_RUN && !expire && STOP_REQ &&
      (!active || (STOP_GATING && NMI_LEVEL)) |=> STOPPED;
  endproperty
  a_stop_entry: assert property (p_stop_entry) // [R17]
    else $error("permitted stop not entered");

  property p_wait_mode;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    STOP_REQ && active && !(STOP_GATING && NMI_LEVEL) |=> WAIT_MODE;
  endproperty
  a_wait_mode: assert property (p_wait_mode) // [R17]
    else $error("stop not turned into wait");

  // Main scenarios reached
  c_expire: cover property (@(posedge SYS_CLK) disable iff (!RESET_N)
    expire);
  c_stop: cover property (@(posedge SYS_CLK) disable iff (!RESET_N)
    state == WDGSR_HALT ##1 WAKEUP);
  c_irq: cover property (@(posedge SYS_CLK) disable iff (!RESET_N)
    IRQ);
  c_wait: cover property (@(posedge SYS_CLK) disable iff (!RESET_N)
    WAIT_MODE);
  c_soft_reset: cover property (@(posedge SYS_CLK) disable iff (!RESET_N)
    wr_gcr && active && !DAT_I[RESTART_BIT]);
endmodule : wdgsr_top

// *** verilog/wdgsr_pkg.sv ***
/*
  Constants for the guard counter block: register map, field positions,
  reset values and timing counts.
  Assumes a 20 MHz system clock and a classic Wishbone register bus.
*/
// Behaviour
// R01: Hardware option keeps watchdog running from reset, arm flag forced to one.
// R02: Software option starts inactive; setting arm flag starts it until reset.
// R03: Seven-bit count decrements once every 3072 system clock cycles.
// R04: Timeout programmable in 64 steps of one decrement interval each.
// R05: Armed and soft restart flag reaching zero gives a reset pulse near 500ns.
// R06: Software refreshes periodically with values FEh down to 02h.
// R07: Writing zero to soft restart flag while armed resets at once.
// R08: Under hardware option the arm flag read value is not reliable.
// R09: Unarmed under software option the counter runs as a 7-bit timer.
// R10: Timer readers should read twice and accept matching values.
// R11: Tick count field holds decrements remaining before forced reset.
// R12: Each refresh write must set the soft restart flag to one.
// R13: Hardware option with stop gating wants the non-maskable line high.
// R14: Timer users should test arm flag at startup and force reset if set.
// R15: Bit 7 is count LSB, bit 2 count MSB, bit 1 restart, bit 0 arm.
// R16: Unarmed, soft restart flag is the timer MSB and causes no reset.
// R17: Active watchdog turns stop into wait unless gating on and line high.
// R18: A register write loads count and flags, counting from next interval.
package wdgsr_pkg;
  localparam logic [3:0]  GCR_OFFSET     = 4'h0; // Guard counter register
  localparam logic [3:0]  IRQ_STAT_OFFS  = 4'h4; // Sticky event status
  localparam logic [3:0]  IRQ_MASK_OFFS  = 4'h8; // Interrupt mask
  localparam logic [7:0]  GCR_RESET      = 8'hFE;
  localparam int          ARM_BIT        = 0;
  localparam int          RESTART_BIT    = 1;
  localparam int          TICK_LSB_POS   = 7;
  localparam int          TICK_MSB_POS   = 2;
  localparam int          CLK_HZ         = 20000000;
  localparam int          TICK_CYCLES    = 3072;
  localparam int          PULSE_NS       = 500;
  localparam int          PULSE_CYCLES   =
    (PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int          EVT_TICK       = 0; // Interval elapsed
  localparam int          EVT_EXPIRE     = 1; // Reset cycle started
  localparam int          EVT_STOP       = 2; // Stop entered
  localparam int          EVT_W          = 3;
endpackage : wdgsr_pkg

// *** test/tb_top.sv ***
/*
  Self-checking bench for the guard counter block: register access,
  timer countdown, forced and timed reset pulses, interrupt, stop modes.
  Assumes a Wishbone slave that acks one cycle after a request, and
  TICK_LEN of 16.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import wdgsr_pkg::*;
  localparam int TL = 16;
  logic        sys_clk, reset_n, hw_act, gating, nmi, stop_req, wakeup;
  logic        cyc, stb, we;
  logic [3:0]  adr, sel;
  logic [31:0] dat_w, dat_r, q, frz;
  logic        ack, pin_n, stopped, wait_mode, irq;
  int          err_total, checks_done, w;
  typedef struct { logic we; logic [3:0] a; logic [31:0] d, e; } wdgsr_row_t;
  wdgsr_row_t  rows [7];

  wdgsr_top #(.TICK_LEN(TL)) dut_u (.SYS_CLK(sys_clk), .RESET_N(reset_n),
    .HW_ACTIVATION(hw_act), .STOP_GATING(gating), .NMI_LEVEL(nmi),
    .STOP_REQ(stop_req), .WAKEUP(wakeup), .CYC_I(cyc), .STB_I(stb),
    .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_w), .DAT_O(dat_r),
    .ACK_O(ack), .RESET_PIN_N(pin_n), .STOPPED(stopped),
    .WAIT_MODE(wait_mode), .IRQ(irq));

  // Free-running 50 ns clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic conclude();
    if (err_total == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One classic cycle; request held until ack is sampled high
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    sel <= 4'hF;
    dat_w <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    r = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) begin
      err_total++;
      conclude();
    end
  endtask

  // Register image: count LSB in bit 7, count MSB in bit 1
  function automatic logic [31:0] img(input int c, input logic arm);
    logic [31:0] v;
    v = 32'h0;
    v[1] = c[6];
    for (int i = 0; i < 6; i++) v[7-i] = c[i];
    v[0] = arm;
    return v;
  endfunction

  // Waits for the pulse, then counts its low cycles
  task automatic pulse(input int bound, output int wl);
    int n;
    n = 0;
    wl = 0;
    while (pin_n !== 1'b0 && n < bound) begin
      @(posedge sys_clk);
      n++;
    end
    while (pin_n === 1'b0 && wl < 40) begin
      @(posedge sys_clk);
      wl++;
    end
    if (n >= bound || wl >= 40) begin
      err_total++;
      conclude();
    end
  endtask

  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
  endtask

  initial begin
    err_total = 0; checks_done = 0;
    reset_n = 1'b0; hw_act = 1'b0; gating = 1'b0; nmi = 1'b0;
    stop_req = 1'b0; wakeup = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0;
    adr = 4'h0; sel = 4'hF; dat_w = 32'h0;
    rows = '{'{1'b0, 4'h0, 32'h0, 32'hFE}, '{1'b1, 4'h0, 32'h82, 32'h0},
             '{1'b0, 4'h0, 32'h0, 32'h82}, '{1'b1, 4'h0, 32'h7C, 32'h0},
             '{1'b0, 4'h0, 32'h0, 32'h7C}, '{1'b0, 4'hC, 32'h0, 32'h0},
             '{1'b1, 4'h8, 32'h2, 32'h0}};
    do_reset();
    chk(pin_n, 1'b1);
    // Ordinary accesses, reads compared against the row
    foreach (rows[i]) begin
      bus(rows[i].we, rows[i].a, rows[i].d, q);
      if (!rows[i].we) chk(q, rows[i].e);
    end
    chk(pin_n, 1'b1);
    // Plain timer: one decrement per interval, also across the flag
    foreach (rows[i]) if (i < 2) begin
      bus(1'b1, 4'h0, img(100 - 36 * i, 1'b0), q);
      repeat (TL + TL / 2) @(posedge sys_clk);
      bus(1'b0, 4'h0, 32'h0, frz);
      bus(1'b0, 4'h0, 32'h0, q);
      chk(q, frz);
      chk(q, img(99 - 36 * i, 1'b0));
    end
    chk(pin_n, 1'b1);
    bus(1'b0, 4'h4, 32'h0, q);
    chk(q, 32'h1);
    chk(irq, 1'b0);
    // Arming with the restart flag clear forces a reset at once
    bus(1'b1, 4'h0, 32'hFD, q);
    pulse(20, w);
    chk(w, PULSE_CYCLES);
    bus(1'b1, 4'h0, 32'hFF, q);
    chk(irq, 1'b1);
    bus(1'b1, 4'h0, 32'hFE, q);
    bus(1'b0, 4'h0, 32'h0, q);
    chk(q, 32'hFF);
    bus(1'b1, 4'h4, 32'h2, q);
    repeat (2) @(posedge sys_clk);
    chk(irq, 1'b0);
    // Timed expiry: 66 reaches 63 after three intervals
    bus(1'b1, 4'h0, img(66, 1'b1), q);
    w = 0;
    repeat (2 * TL + TL / 2) begin
      @(posedge sys_clk);
      if (pin_n !== 1'b1) w++;
    end
    chk(w, 0);
    pulse(TL, w);
    chk(w, PULSE_CYCLES);
    bus(1'b1, 4'h0, 32'hFF, q);
    // Armed stop without gating becomes wait
    stop_req <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk({wait_mode, stopped}, 2'b10);
    stop_req <= 1'b0;
    gating <= 1'b1; nmi <= 1'b1;
    repeat (2) @(posedge sys_clk);
    stop_req <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(stopped, 1'b1);
    bus(1'b0, 4'h0, 32'h0, frz);
    chk(frz, 32'hFF);
    repeat (3 * TL) @(posedge sys_clk);
    bus(1'b0, 4'h0, 32'h0, q);
    chk(q, frz);
    chk(q, 32'hFF);
    stop_req <= 1'b0; wakeup <= 1'b1;
    @(posedge sys_clk);
    wakeup <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk(stopped, 1'b0);
    // Hardware option: arm flag forced, soft reset still works
    hw_act <= 1'b1;
    do_reset();
    chk({pin_n, irq, stopped, wait_mode}, 4'b1000);
    bus(1'b0, 4'h0, 32'h0, q);
    chk(q, 32'hFF);
    bus(1'b1, 4'h0, 32'hFC, q);
    pulse(20, w);
    chk(w, PULSE_CYCLES);
    conclude();
  end
endmodule // tb_top
